// ==== core/cfg_loader.sv ====
// Parallel byte configuration loader with test-port priority.
// What this block does
// - In user mode, request line low starts a new configuration cycle.
// - Status line held low for the whole power-on delay.
// - Load-complete stays low after power-up and during configuration until the second-last byte is in.
// - Load-complete goes low within 500 ns of request low.
// - Status goes low within 500 ns of request low.
// - Status low pulse lasts at least 45 us, normally at most 230 us.
// - Status released within 230 us of request going high.
// - Internal oscillator start-up: user mode 300 to 650 us after done.
// - User init clock enabled no earlier than four byte periods after done.
// - User clock option: enable delay plus init cycles, clock supplied.
// - Byte bus released for user use per dual-purpose setting.
// - Test-port configuration wins and terminates any load in progress.
// - In active serial mode no clock output during test-port config.
// - All user pins high impedance during test-port configuration.
// - Data input sampled on rising test clock edges in Shift-IR and Shift-DR only.
// - Data output updated on falling edges, high impedance when idle.
// - Mode select evaluated on each rising test clock edge.
// - Byte bus captured on byte clock rising edge until the final byte is in.
// - Load-complete rises one byte before the final byte.
// - Error with auto-restart releases status; else host pulses request.
`timescale 1ns/1ps
`default_nettype none

module cfg_loader
  import cfg_loader_pkg::*;
#(
  parameter int unsigned POR_CYCLES = POR_CYC,
  parameter int unsigned STATUS_MIN_CYCLES = STATUS_MIN_CYC,
  parameter int unsigned CD2UM_CYCLES = CD2UM_CYC,
  parameter int unsigned LOAD_BYTE_COUNT = LOAD_BYTES,
  parameter int unsigned INIT_CYCLES = INIT_CLK_CYCLES
) (
  input wire logic clock_i, // System clock, 100 MHz
  input wire logic reset_n_i, // Power-on reset, async active low
  input wire logic config_request_n_i, // Request pin, active low
  input wire logic [1:0] scheme_select_i, // Scheme strap pins
  input wire logic use_user_clock_i, // Start-up from user init clock
  input wire logic user_init_clock_i, // User init clock pin
  input wire logic auto_restart_i, // Restart after error option
  input wire logic dual_purpose_user_i, // Byte bus becomes user I/O
  input wire logic cfg_error_i, // Load error from core, system domain
  output logic cfg_status_n_o, // Status line, active low
  output logic load_complete_o, // Load-complete pin
  output logic user_mode_o, // Device in user mode
  output logic user_io_hiz_o, // All user pins tri-stated
  output logic data_pins_hiz_o, // Byte bus pins tri-stated
  output logic as_clock_o, // Active serial clock out
  output logic as_clock_oe_o, // Active serial clock enable
  output logic jtag_cfg_active_o, // Test-port configuration running
  input wire logic cfg_byte_clock_i, // Byte clock, link domain
  input wire logic [7:0] cfg_data_i, // Byte bus
  output logic [7:0] cfg_byte_o, // Captured byte, byte clock domain
  output logic cfg_byte_valid_o, // Captured byte strobe
  input wire logic tck_i, // Test clock
  input wire logic tms_i, // Test mode select
  input wire logic tdi_i, // Test data in
  output logic tdo_o, // Test data out
  output logic tdo_oe_o, // Test data out enable
  output logic jtag_bit_o, // Programming bit, test clock domain
  output logic jtag_bit_valid_o // Programming bit strobe
);

  // Refuse sizes that the counters and done timing cannot serve
  if (LOAD_BYTE_COUNT < 2 || STATUS_MIN_CYCLES < 1 || POR_CYCLES < 1 ||
      CD2UM_CYCLES < 1 || INIT_CYCLES < 1) begin : g_bad_param
    $error("cfg_loader: parameter out of range");
  end

  // ==========================================================
  // Pin synchronisers (system domain)
  logic req_n_s1_q, req_n_s2_q;
  logic [1:0] sel_s1_q, sel_s2_q;
  logic uclk_s1_q, uclk_s2_q, uclk_s3_q;
  logic jt_s1_q, jt_s2_q;
  logic done_s1_q, done_s2_q, done_s3_q;
  logic init_s1_q, init_s2_q, init_s3_q;
  logic load_en_q;
  logic done_tgl_q, init_tgl_q, jtag_cfg_q;

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      req_n_s1_q <= 1'b1;
      req_n_s2_q <= 1'b1;
      sel_s1_q <= 2'h0;
      sel_s2_q <= 2'h0;
      {uclk_s1_q, uclk_s2_q, uclk_s3_q} <= 3'h0;
      {jt_s1_q, jt_s2_q} <= 2'h0;
    end else begin
      req_n_s1_q <= config_request_n_i;
      req_n_s2_q <= req_n_s1_q;
      sel_s1_q <= scheme_select_i;
      sel_s2_q <= sel_s1_q;
      {uclk_s1_q, uclk_s2_q, uclk_s3_q} <=
        {user_init_clock_i, uclk_s1_q, uclk_s2_q};
      {jt_s1_q, jt_s2_q} <= {jtag_cfg_q, jt_s1_q};
    end
  end

  // Event chains cleared with the load so a stale toggle never fires
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      {done_s1_q, done_s2_q, done_s3_q} <= 3'h0;
      {init_s1_q, init_s2_q, init_s3_q} <= 3'h0;
    end else if (!load_en_q) begin
      {done_s1_q, done_s2_q, done_s3_q} <= 3'h0;
      {init_s1_q, init_s2_q, init_s3_q} <= 3'h0;
    end else begin
      {done_s1_q, done_s2_q, done_s3_q} <= {done_tgl_q, done_s1_q, done_s2_q};
      {init_s1_q, init_s2_q, init_s3_q} <= {init_tgl_q, init_s1_q, init_s2_q};
    end
  end

  wire req_low = !req_n_s2_q;
  wire jtag_on = jt_s2_q;
  wire done_evt = done_s2_q ^ done_s3_q;
  wire init_evt = init_s2_q ^ init_s3_q;
  wire uclk_rise = uclk_s2_q && !uclk_s3_q;

  // ==========================================================
  // Load sequencer
  load_state_t state_q, state_d;
  logic [31:0] timer_q, timer_d;
  logic [31:0] uclk_cnt_q, uclk_cnt_d;
  logic init_go_q, init_go_d;

  wire status_ok = timer_q >= STATUS_MIN_CYCLES;
  wire cd2cu_ok = timer_q >= CD2CU_CYC;
  wire state_chg = state_d != state_q;

  always_comb begin
    state_d = state_q;
    init_go_d = init_go_q;
    uclk_cnt_d = uclk_cnt_q;
    case (state_q)
      ST_POR: begin
        if (timer_q >= POR_CYCLES - 1) begin
          state_d = ST_RESET;
        end
      end
      ST_RESET: begin
        if (!req_low && status_ok) begin
          state_d = ST_LOAD;
        end
      end
      ST_LOAD: begin
        if (cfg_error_i) begin
          state_d = ST_ERROR;
        end else if (done_evt) begin
          state_d = ST_INIT;
        end
      end
      ST_INIT: begin
        if (init_evt) begin
          init_go_d = 1'b1;
        end
        if (init_go_q && use_user_clock_i) begin
          if (cd2cu_ok && uclk_rise) begin
            uclk_cnt_d = uclk_cnt_q + 32'h1;
          end
          if (uclk_cnt_q >= INIT_CYCLES) begin
            state_d = ST_USER;
          end
        end else if (init_go_q && timer_q >= CD2UM_CYCLES) begin
          state_d = ST_USER;
        end
      end
      ST_USER: state_d = ST_USER;
      ST_ERROR: begin
        if (auto_restart_i && status_ok) begin
          state_d = ST_LOAD;
        end
      end
      ST_JTAG: begin
        if (!jtag_on) begin
          state_d = ST_RESET;
        end
      end
      default: state_d = ST_RESET;
    endcase
    if (state_q != ST_POR && state_q != ST_JTAG) begin
      if (jtag_on) begin
        state_d = ST_JTAG;
      end else if (req_low && state_q != ST_RESET) begin
        state_d = ST_RESET;
      end
    end
    if (state_d != state_q) begin
      init_go_d = 1'b0;
      uclk_cnt_d = 32'h0;
    end
  end

  // Timer restarts on every state change except reset to test port with request low, and when init begins
  always_comb begin
    timer_d = timer_q + 32'h1;
    if (state_chg || (state_q == ST_INIT && !init_go_q)) begin
      timer_d = 32'h0;
    end
    if (state_q == ST_RESET && req_low) begin
      timer_d = timer_q + 32'h1;
    end
  end

  logic status_n_q, complete_q, user_q, as_clk_q;
  wire st_low = state_d == ST_POR || state_d == ST_RESET ||
                state_d == ST_ERROR;
  wire done_hi = state_d == ST_INIT || state_d == ST_USER;
  wire as_run = state_q == ST_LOAD && sel_s2_q == ACTIVE_SERIAL_MODE &&
                !jtag_on;

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_q <= ST_POR;
      timer_q <= 32'h0;
      uclk_cnt_q <= 32'h0;
      init_go_q <= 1'b0;
    end else begin
      state_q <= state_d;
      timer_q <= timer_d;
      uclk_cnt_q <= uclk_cnt_d;
      init_go_q <= init_go_d;
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      status_n_q <= 1'b0;
      complete_q <= 1'b0;
      user_q <= 1'b0;
      load_en_q <= 1'b0;
      as_clk_q <= 1'b0;
    end else begin
      status_n_q <= !st_low;
      complete_q <= done_hi;
      user_q <= state_d == ST_USER;
      load_en_q <= state_d == ST_LOAD || state_d == ST_INIT;
      as_clk_q <= as_run ? !as_clk_q : 1'b0;
    end
  end

  assign cfg_status_n_o = status_n_q;
  assign load_complete_o = complete_q;
  assign user_mode_o = user_q;
  assign user_io_hiz_o = !user_q || jtag_on;
  assign data_pins_hiz_o = !(user_q && dual_purpose_user_i) || jtag_on;
  assign as_clock_o = as_clk_q;
  assign as_clock_oe_o = as_run;
  assign jtag_cfg_active_o = jtag_on;

  // ==========================================================
  // Byte clock domain, held in reset outside the load and init states
  logic [31:0] byte_cnt_q;
  logic done_b_q;
  logic [1:0] fall_cnt_q;
  logic [7:0] byte_q;
  logic byte_vld_q;
  wire byte_rst_n = reset_n_i && load_en_q;
  wire byte_take = byte_cnt_q < LOAD_BYTE_COUNT;

  always_ff @(posedge cfg_byte_clock_i or negedge byte_rst_n) begin
    if (!byte_rst_n) begin
      byte_cnt_q <= 32'h0;
      done_b_q <= 1'b0;
      done_tgl_q <= 1'b0;
      byte_q <= 8'h00;
      byte_vld_q <= 1'b0;
    end else begin
      byte_vld_q <= byte_take;
      if (byte_take) begin
        byte_q <= cfg_data_i;
        byte_cnt_q <= byte_cnt_q + 32'h1;
      end
      if (!done_b_q && byte_cnt_q == LOAD_BYTE_COUNT - 2) begin
        done_b_q <= 1'b1;
        done_tgl_q <= !done_tgl_q;
      end
    end
  end

  always_ff @(negedge cfg_byte_clock_i or negedge byte_rst_n) begin
    if (!byte_rst_n) begin
      fall_cnt_q <= 2'h0;
      init_tgl_q <= 1'b0;
    end else if (done_b_q && fall_cnt_q < 2'(INIT_FALL_EDGES)) begin
      fall_cnt_q <= fall_cnt_q + 2'h1;
      if (fall_cnt_q == 2'(INIT_FALL_EDGES - 1)) begin
        init_tgl_q <= !init_tgl_q;
      end
    end
  end

  assign cfg_byte_o = byte_q;
  assign cfg_byte_valid_o = byte_vld_q;

  // ==========================================================
  // Test access port, test clock domain
  tap_state_t tap_q, tap_d;
  logic [IR_W-1:0] ir_sh_q, ir_q;
  logic bypass_q, tdi_q, bit_vld_q, tdo_q, tdo_oe_q;

  always_comb begin
    case (tap_q)
      TAP_RESET: tap_d = tms_i ? TAP_RESET : TAP_IDLE;
      TAP_IDLE: tap_d = tms_i ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_DR: tap_d = tms_i ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR: tap_d = tms_i ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_SHIFT_DR: tap_d = tms_i ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_EXIT1_DR: tap_d = tms_i ? TAP_UPD_DR : TAP_PAUSE_DR;
      TAP_PAUSE_DR: tap_d = tms_i ? TAP_EXIT2_DR : TAP_PAUSE_DR;
      TAP_EXIT2_DR: tap_d = tms_i ? TAP_UPD_DR : TAP_SHIFT_DR;
      TAP_SEL_IR: tap_d = tms_i ? TAP_RESET : TAP_CAP_IR;
      TAP_CAP_IR: tap_d = tms_i ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_SHIFT_IR: tap_d = tms_i ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_EXIT1_IR: tap_d = tms_i ? TAP_UPD_IR : TAP_PAUSE_IR;
      TAP_PAUSE_IR: tap_d = tms_i ? TAP_EXIT2_IR : TAP_PAUSE_IR;
      TAP_EXIT2_IR: tap_d = tms_i ? TAP_UPD_IR : TAP_SHIFT_IR;
      TAP_UPD_DR, TAP_UPD_IR: tap_d = tms_i ? TAP_SEL_DR : TAP_IDLE;
      default: tap_d = TAP_RESET;
    endcase
  end

  wire in_shift_dr = tap_q == TAP_SHIFT_DR;
  wire in_shift_ir = tap_q == TAP_SHIFT_IR;

  always_ff @(posedge tck_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tap_q <= TAP_RESET;
      ir_sh_q <= IR_CAPTURE;
      ir_q <= IR_BYPASS;
      bypass_q <= 1'b0;
      tdi_q <= 1'b0;
      bit_vld_q <= 1'b0;
      jtag_cfg_q <= 1'b0;
    end else begin
      tap_q <= tap_d;
      bit_vld_q <= in_shift_dr && jtag_cfg_q;
      if (in_shift_dr) begin
        tdi_q <= tdi_i;
        bypass_q <= tdi_i;
      end
      if (tap_q == TAP_CAP_IR) begin
        ir_sh_q <= IR_CAPTURE;
      end else if (in_shift_ir) begin
        ir_sh_q <= {tdi_i, ir_sh_q[IR_W-1:1]};
      end
      if (tap_q == TAP_RESET) begin
        ir_q <= IR_BYPASS;
        jtag_cfg_q <= 1'b0;
      end else if (tap_q == TAP_UPD_IR) begin
        ir_q <= ir_sh_q;
        jtag_cfg_q <= ir_sh_q == IR_CFG_PROG;
      end
    end
  end

  // Output changes on the falling edge so the far side samples it mid-bit
  always_ff @(negedge tck_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tdo_q <= 1'b0;
      tdo_oe_q <= 1'b0;
    end else begin
      tdo_q <= in_shift_ir ? ir_sh_q[0] : bypass_q;
      tdo_oe_q <= in_shift_ir || in_shift_dr;
    end
  end

  assign tdo_o = tdo_q;
  assign tdo_oe_o = tdo_oe_q;
  assign jtag_bit_o = tdi_q;
  assign jtag_bit_valid_o = bit_vld_q;

endmodule

`default_nettype wire

// ==== core/cfg_loader_pkg.sv ====
// Constants shared by the configuration loader.
package cfg_loader_pkg;

  // ==========================================================
  // System clock
  localparam int unsigned CLK_PERIOD_NS = 10;

  // ==========================================================
  // Request and status timing
  localparam int unsigned REQ_TO_LOW_MAX_NS = 500;
  localparam int unsigned STATUS_LOW_MIN_US = 45;
  localparam int unsigned STATUS_LOW_MAX_US = 230;
  localparam int unsigned STATUS_MIN_CYC =
    (STATUS_LOW_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned POR_DELAY_US = 100;
  localparam int unsigned POR_CYC = POR_DELAY_US * 1000 / CLK_PERIOD_NS;

  // ==========================================================
  // Start-up timing
  localparam int unsigned CD2UM_MIN_US = 300;
  localparam int unsigned CD2UM_MAX_US = 650;
  localparam int unsigned CD2UM_CYC =
    (CD2UM_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned BYTE_CLK_MAX_PERIOD_NS = 10;
  localparam int unsigned CD2CU_PERIODS = 4;
  localparam int unsigned CD2CU_NS = CD2CU_PERIODS * BYTE_CLK_MAX_PERIOD_NS;
  localparam int unsigned CD2CU_CYC =
    (CD2CU_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned INIT_FALL_EDGES = 2;
  localparam int unsigned INIT_CLK_CYCLES = 64;
  localparam int unsigned LOAD_BYTES = 1024;

  // ==========================================================
  // Scheme select encodings
  localparam logic [1:0] PARALLEL_BYTE_LOAD_MODE = 2'h0;
  localparam logic [1:0] ACTIVE_SERIAL_MODE = 2'h1;
  localparam logic [1:0] PASSIVE_SERIAL_MODE = 2'h2;

  // ==========================================================
  // Test access port
  localparam int unsigned IR_W = 4;
  localparam logic [3:0] IR_CAPTURE = 4'h1;
  localparam logic [3:0] IR_BYPASS = 4'hF;
  localparam logic [3:0] IR_CFG_PROG = 4'h2;

  typedef enum logic [2:0] {
    ST_POR, ST_RESET, ST_LOAD, ST_INIT, ST_USER, ST_ERROR, ST_JTAG
  } load_state_t;

  typedef enum logic [3:0] {
    TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR,
    TAP_PAUSE_DR, TAP_EXIT2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR,
    TAP_SHIFT_IR, TAP_EXIT1_IR, TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
  } tap_state_t;

endpackage

// ==== test/cfg_loader_sva.sv ====
// Port-level checks for the configuration loader.
`timescale 1ns/1ps
`default_nettype none
module cfg_loader_sva
  import cfg_loader_pkg::*;
#(
  parameter int unsigned POR_CYCLES = 20,
  parameter int unsigned STATUS_MIN_CYCLES = 10,
  parameter int unsigned CD2UM_CYCLES = 40,
  parameter int unsigned INIT_CYCLES = 4
) (
  input wire logic clock_i, // System clock
  input wire logic reset_n_i, // Async reset
  input wire logic config_request_n_i, // Request pin
  input wire logic [1:0] scheme_select_i, // Scheme straps
  input wire logic use_user_clock_i, // User clock start-up
  input wire logic dual_purpose_user_i, // Byte bus as user I/O
  input wire logic cfg_status_n_o, // Status
  input wire logic load_complete_o, // Load-complete
  input wire logic user_mode_o, // User mode
  input wire logic user_io_hiz_o, // User pins off
  input wire logic data_pins_hiz_o, // Byte bus off
  input wire logic as_clock_oe_o, // Serial clock enable
  input wire logic jtag_cfg_active_o // Test-port config
);
  // Status may stay low 230 us after the request returns high
  localparam int unsigned STATUS_MAX = STATUS_LOW_MAX_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned UM_MAX = CD2UM_CYCLES * CD2UM_MAX_US / CD2UM_MIN_US;
  int unsigned por_q, low_q, hi_q, done_q;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);
  // ==========================================================
  // Cycle counters
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      por_q <= 0;
      low_q <= 0;
      hi_q <= 0;
      done_q <= 0;
    end else begin
      por_q <= (por_q < POR_CYCLES) ? por_q + 1 : por_q;
      low_q <= cfg_status_n_o ? 0 : low_q + 1;
      hi_q <= (!cfg_status_n_o && config_request_n_i) ? hi_q + 1 : 0;
      done_q <= (load_complete_o && !user_mode_o) ? done_q + 1 : 0;
    end
  end
  // ==========================================================
  // Properties
  property p_por_low;
    por_q < POR_CYCLES |-> !cfg_status_n_o;
  endproperty
  a_por_low: assert property (p_por_low)
    else $error("status high in power-on delay");
  property p_done_low;
    !cfg_status_n_o |-> !load_complete_o;
  endproperty
  a_done_low: assert property (p_done_low)
    else $error("load-complete high while status low");
  property p_req_status;
    $fell(config_request_n_i) && !jtag_cfg_active_o && por_q >= POR_CYCLES
      |-> ##[1:50] !cfg_status_n_o;
  endproperty
  a_req_status: assert property (p_req_status)
    else $error("status not low after request");
  property p_req_done;
    $fell(config_request_n_i) && load_complete_o |-> ##[1:50] !load_complete_o;
  endproperty
  a_req_done: assert property (p_req_done)
    else $error("load-complete not low after request");
  property p_req_user;
    $fell(config_request_n_i) && user_mode_o |-> ##[1:50] !user_mode_o;
  endproperty
  a_req_user: assert property (p_req_user)
    else $error("user mode kept after request");
  property p_status_min;
    $rose(cfg_status_n_o) |-> low_q >= STATUS_MIN_CYCLES - 1;
  endproperty
  a_status_min: assert property (p_status_min)
    else $error("status low pulse too short");
  property p_status_max;
    hi_q <= STATUS_MAX;
  endproperty
  a_status_max: assert property (p_status_max)
    else $error("status not released in time");
  property p_startup;
    $rose(user_mode_o) && !use_user_clock_i
      |-> done_q >= CD2UM_CYCLES && done_q <= UM_MAX;
  endproperty
  a_startup: assert property (p_startup)
    else $error("start-up time out of range");
  property p_user_clk;
    $rose(user_mode_o) && use_user_clock_i |-> done_q >= INIT_CYCLES + CD2CU_CYC;
  endproperty
  a_user_clk: assert property (p_user_clk)
    else $error("user clock start-up too early");
  property p_bus_free;
    $rose(user_mode_o) && dual_purpose_user_i |-> ##[0:2] !data_pins_hiz_o;
  endproperty
  a_bus_free: assert property (p_bus_free)
    else $error("byte bus not released");
  property p_jtag_hiz;
    jtag_cfg_active_o[*3] |-> user_io_hiz_o;
  endproperty
  a_jtag_hiz: assert property (p_jtag_hiz)
    else $error("user pins driven in test config");
  property p_as_quiet;
    (jtag_cfg_active_o && scheme_select_i == ACTIVE_SERIAL_MODE)[*3]
      |-> !as_clock_oe_o;
  endproperty
  a_as_quiet: assert property (p_as_quiet)
    else $error("serial clock out in test config");
endmodule
bind cfg_loader cfg_loader_sva #(
  .POR_CYCLES(POR_CYCLES),
  .STATUS_MIN_CYCLES(STATUS_MIN_CYCLES),
  .CD2UM_CYCLES(CD2UM_CYCLES),
  .INIT_CYCLES(INIT_CYCLES)
) u_sva (.*);
`default_nettype wire

// ==== test/cfg_host.sv ====
// Host model that drives the request line and byte bus.
`timescale 1ns/1ps
`default_nettype none
module cfg_host #(
  parameter int unsigned N = 4
) (
  input wire logic status_n_i, // Status from device
  input wire logic complete_i, // Load-complete from device
  output logic request_n_o, // Request, active low
  output logic byte_clock_o, // Byte clock, still between frames
  output logic [7:0] data_o // Byte bus
);
  int early;
  initial begin
    request_n_o = 1'b1;
    byte_clock_o = 1'b0;
    data_o = 8'h5A;
  end
  // ==========================================================
  // Transfers
  task automatic request();
    request_n_o = 1'b0;
    #600;
    request_n_o = 1'b1;
  endtask
  // Gap after each byte is a pause, which has no upper limit
  task automatic byte_out(input logic [7:0] d);
    data_o = d;
    #5;
    byte_clock_o = 1'b1;
    #3;
    byte_clock_o = 1'b0;
    #100;
  endtask
  task automatic load();
    #230000;
    for (int i = 0; i < 300 && !status_n_i; i++) #1000;
    #2000;
    early = -1;
    for (int i = 0; i < N && status_n_i; i++) begin
      if (complete_i && early < 0) early = i;
      byte_out(8'hA0 + i[7:0]);
    end
    byte_out(~data_o);
    byte_out(~data_o);
    data_o = ~data_o;
  endtask
endmodule
`default_nettype wire

// ==== test/test_cfg_loader.sv ====
// Self-checking bench for the configuration loader.
`timescale 1ns/1ps
`default_nettype none
module test_cfg_loader;
  import cfg_loader_pkg::*;
  localparam int unsigned NB = 4;
  // Reset, then idle, Sel-DR, Sel-IR, Capture-IR, Shift-IR
  localparam logic [9:0] TMS_SEQ = 10'h0DF;
  logic clock_i, reset_n_i, config_request_n_i, use_user_clock_i;
  logic user_init_clock_i, auto_restart_i, dual_purpose_user_i;
  logic cfg_error_i, cfg_status_n_o, load_complete_o, user_mode_o;
  logic user_io_hiz_o, data_pins_hiz_o, as_clock_o, as_clock_oe_o;
  logic jtag_cfg_active_o, cfg_byte_clock_i, cfg_byte_valid_o;
  logic tck_i, tms_i, tdi_i, tdo_o, tdo_oe_o, jtag_bit_o, jtag_bit_valid_o;
  logic tdo_s, oe_s, as_s;
  logic [1:0] scheme_select_i;
  logic [7:0] cfg_data_i, cfg_byte_o;
  logic [7:0] got[$];
  int err_count, samples_checked;
  cfg_loader #(
    .POR_CYCLES(20),
    .STATUS_MIN_CYCLES(10),
    .CD2UM_CYCLES(40),
    .LOAD_BYTE_COUNT(NB),
    .INIT_CYCLES(4)
  ) dut_u (.*);
  cfg_host #(.N(NB)) u_host (
    .status_n_i(cfg_status_n_o),
    .complete_i(load_complete_o),
    .request_n_o(config_request_n_i),
    .byte_clock_o(cfg_byte_clock_i),
    .data_o(cfg_data_i)
  );
  // ==========================================================
  // Helpers
  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic results();
    if (err_count == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic wait_hi(input bit user);
    for (int i = 0; i < 30000; i++) begin
      if ((user ? user_mode_o : cfg_status_n_o) === 1'b1) break;
      @(posedge clock_i);
      #1;
    end
  endtask
  // TMS and TDI settle half a period before the rising edge
  task automatic tap(input logic tms, input logic tdi);
    tms_i = tms;
    tdi_i = tdi;
    #20;
    tdo_s = tdo_o;
    oe_s = tdo_oe_o;
    tck_i = 1'b1;
    #20;
    tck_i = 1'b0;
  endtask
  always @(negedge cfg_byte_clock_i) begin
    if (cfg_byte_valid_o === 1'b1) got.push_back(cfg_byte_o);
  end
  always #25 user_init_clock_i = ~user_init_clock_i;
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  initial begin
    #800000;
    err_count++;
    results();
  end
  // ==========================================================
  // Tests
  initial begin
    {reset_n_i, use_user_clock_i, user_init_clock_i, auto_restart_i} = 4'h0;
    {cfg_error_i, tck_i, tms_i, tdi_i, dual_purpose_user_i} = 5'h07;
    scheme_select_i = PARALLEL_BYTE_LOAD_MODE;
    repeat (20) @(posedge clock_i);
    #1 reset_n_i = 1'b1;
    repeat (18) @(posedge clock_i);
    #1;
    check("status_por", cfg_status_n_o, 1'b0);
    check("done_por", load_complete_o, 1'b0);
    u_host.load();
    check("done_early", u_host.early[7:0], 8'(NB - 1));
    check("byte_count", 8'(got.size()), 8'(NB));
    for (int i = 0; i < NB; i++) check("byte", got[i], 8'(8'hA0 + i));
    wait_hi(1'b1);
    check("user", user_mode_o, 1'b1);
    check("bus_hiz", data_pins_hiz_o, 1'b0);
    use_user_clock_i = 1'b1;
    u_host.request();
    check("status_req", cfg_status_n_o, 1'b0);
    check("done_req", load_complete_o, 1'b0);
    check("user_req", user_mode_o, 1'b0);
    u_host.load();
    wait_hi(1'b1);
    check("user_clk", user_mode_o, 1'b1);
    {use_user_clock_i, auto_restart_i} = 2'h1;
    u_host.request();
    wait_hi(1'b0);
    check("status_load", cfg_status_n_o, 1'b1);
    cfg_error_i = 1'b1;
    repeat (3) @(posedge clock_i);
    #1 cfg_error_i = 1'b0;
    repeat (4) @(posedge clock_i);
    #1;
    check("status_err", cfg_status_n_o, 1'b0);
    wait_hi(1'b0);
    check("status_retry", cfg_status_n_o, 1'b1);
    scheme_select_i = ACTIVE_SERIAL_MODE;
    // Serial clock must run while loading, before the test port takes over
    repeat (3) @(posedge clock_i);
    #1;
    check("as_oe_load", as_clock_oe_o, 1'b1);
    as_s = as_clock_o;
    @(posedge clock_i);
    #1;
    check("as_clk", as_clock_o, !as_s);
    for (int i = 0; i < 10; i++) tap(TMS_SEQ[i], 1'b0);
    for (int i = 0; i < 4; i++) begin
      tap(i == 3, IR_CFG_PROG[i]);
      if (i < 2) check("tdo", tdo_s, i == 0);
      if (i == 0) check("tdo_oe", oe_s, 1'b1);
    end
    tap(1'b1, 1'b0);
    tap(1'b0, 1'b0);
    check("tdo_idle", oe_s, 1'b0);
    // Select-DR, Capture-DR, two Shift-DR bits, then out to Update-DR
    tap(1'b1, 1'b0);
    tap(1'b0, 1'b0);
    tap(1'b0, 1'b0);
    tap(1'b0, 1'b1);
    check("cfg_bit", jtag_bit_o, 1'b1);
    check("cfg_bit_vld", jtag_bit_valid_o, 1'b1);
    tap(1'b1, 1'b0);
    check("tdo_dr", tdo_s, 1'b1);
    tap(1'b1, 1'b0);
    repeat (10) @(posedge clock_i);
    #1;
    check("jtag_on", jtag_cfg_active_o, 1'b1);
    check("io_hiz", user_io_hiz_o, 1'b1);
    check("as_oe", as_clock_oe_o, 1'b0);
    for (int i = 0; i < 5; i++) tap(1'b1, 1'b0);
    // Status pulse after leaving test config lasts only the minimum
    repeat (3) @(posedge clock_i);
    #1;
    check("jtag_off", jtag_cfg_active_o, 1'b0);
    check("status_jtag", cfg_status_n_o, 1'b0);
    results();
  end
endmodule
`default_nettype wire
